// ---- hw/msr_pkg.sv ----
package msr_pkg;

  // ----------------------------------------------------------------
  // Special register map
  // ----------------------------------------------------------------
  localparam int         SFR_COUNT = 19;
  localparam logic [4:0] SFR_NONE  = 5'h1f;
  localparam logic [4:0] IX_SP     = 5'h00;
  localparam logic [4:0] IX_POWER_CONTROL   = 5'h03;
  localparam logic [4:0] IX_P1     = 5'h0a;
  localparam logic [4:0] IX_IE     = 5'h0d;
  localparam logic [4:0] IX_P3     = 5'h0e;
  localparam logic [4:0] IX_PSW    = 5'h10;
  localparam logic [4:0] IX_ACC    = 5'h11;

  // Order: stack, dptr low/high, power, timer ctl/mode, timer bytes,
  // port 1, serial ctl/buffer, irq enable, port 3, priority, status,
  // accumulator, helper.
  localparam logic [7:0] SFR_ADDR [SFR_COUNT] = '{
    8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c,
    8'h8d, 8'h90, 8'h98, 8'h99, 8'ha8, 8'hb0, 8'hb8, 8'hd0, 8'he0,
    8'hf0};
  localparam logic [7:0] SFR_RST [SFR_COUNT] = '{
    8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam logic [7:0] SFR_WMASK [SFR_COUNT] = '{
    8'hff, 8'hff, 8'hff, 8'h8c, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h9f, 8'hff, 8'h1f, 8'hff, 8'hff,
    8'hff};

  // ----------------------------------------------------------------
  // Fields, pins and timing
  // ----------------------------------------------------------------
  localparam int         POWER_CONTROL_IDLE_BIT  = 0;
  localparam int         POWER_CONTROL_PD_BIT    = 1;
  localparam int         IE_ALL_BIT     = 7;
  localparam int         IRQ_COUNT      = 5;
  localparam int         CMP_PLUS_BIT   = 0;
  localparam int         CMP_MINUS_BIT  = 1;
  localparam int         RXD_BIT        = 0;
  localparam int         INT0_BIT       = 2;
  localparam int         EXT_IRQ_ONE_PIN_BIT       = 3;
  localparam int         T0_BIT         = 4;
  localparam int         T1_BIT         = 5;
  localparam logic [7:0] TXD_MASK       = 8'h02;
  localparam logic [7:0] P1_PULLUP      = 8'hfc;
  localparam logic [7:0] P3_GPIO_MASK   = 8'hbf;
  localparam logic [7:0] LATCH_ONES     = 8'hff;
  localparam int         RAM_DEPTH      = 128;
  localparam int         MC_OSC_PERIODS = 12;
  localparam int         RST_HOLD_MC    = 2;
  localparam int         RST_HOLD_OSC   = MC_OSC_PERIODS * RST_HOLD_MC;
  localparam logic [10:0] VEC_BASE      = 11'h003;
  localparam logic [10:0] VEC_STEP      = 11'h008;

  typedef enum logic [2:0] {
    PWR_RUN  = 3'b001,
    PWR_IDLE = 3'b010,
    PWR_DOWN = 3'b100
  } msr_pwr_type;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] sfr_index(input logic [7:0] addr);
    logic [4:0] idx;
    idx = SFR_NONE;
    for (int i = 0; i < SFR_COUNT; i++)
      if (SFR_ADDR[i] == addr)
        idx = 5'(i);
    return idx;
  endfunction : sfr_index

  // Takes a new level only where the second and third stages agree.
  function automatic logic [7:0] settle(input logic [7:0] s2,
                                        input logic [7:0] s3,
                                        input logic [7:0] old);
    return (~(s2 ^ s3) & s2) | ((s2 ^ s3) & old);
  endfunction : settle

  function automatic logic [10:0] vec_addr(input logic [4:0] req);
    logic [10:0] a;
    a = VEC_BASE;
    for (int i = IRQ_COUNT - 1; i >= 0; i--)
      if (req[i])
        a = 11'(VEC_BASE + VEC_STEP * 11'(i));
    return a;
  endfunction : vec_addr

endpackage : msr_pkg

// ---- hw/msr_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
module msr_ram #(
  parameter int DEPTH = msr_pkg::RAM_DEPTH,
  parameter int WIDTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_addr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_rdata
);

  // The array has no reset so that its contents survive any reset.
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
      mem[i_addr] <= i_wdata;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= '0;
    else
      o_rdata <= mem[i_addr];
  end

endmodule : msr_ram
`default_nettype wire

// ---- hw/msr_rst_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
module msr_rst_seq (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_rst_pin,
  output logic      o_pin_high,
  output logic      o_sys_rst,
  output logic      o_mc_pulse,
  output logic      o_clk_phase
);

  logic       s1;
  logic       s2;
  logic       s3;
  logic [3:0] osc_cnt;
  logic [4:0] hold_cnt;
  logic       mc_end;
  logic       hold_done;
  logic [7:0] pin_next;

  assign mc_end    = osc_cnt == 4'(msr_pkg::MC_OSC_PERIODS - 1);
  assign hold_done = hold_cnt == 5'(msr_pkg::RST_HOLD_OSC - 1);
  assign pin_next  = msr_pkg::settle({7'h00, s2}, {7'h00, s3},
                                     {7'h00, o_pin_high});

  // ----------------------------------------------------------------
  // Clock phases and reset qualification
  // ----------------------------------------------------------------
  // No state depends on the clock rate, so a stopped clock only pauses.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1          <= 1'b0;
      s2          <= 1'b0;
      s3          <= 1'b0;
      o_pin_high  <= 1'b0;
      o_clk_phase <= 1'b0;
      osc_cnt     <= 4'h0;
      o_mc_pulse  <= 1'b0;
      hold_cnt    <= 5'h00;
      o_sys_rst   <= 1'b1;
    end
    else
    begin
      s1          <= i_rst_pin;
      s2          <= s1;
      s3          <= s2;
      o_pin_high  <= pin_next[0];
      o_clk_phase <= ~o_clk_phase;
      osc_cnt     <= mc_end ? 4'h0 : osc_cnt + 4'h1;
      o_mc_pulse  <= mc_end;
      if (!o_pin_high)
      begin
        hold_cnt  <= 5'h00;
        o_sys_rst <= 1'b0;
      end
      else if (!hold_done)
        hold_cnt <= hold_cnt + 5'h01;
      else
        o_sys_rst <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_phase_divide: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_clk_phase != $past(o_clk_phase))
    else $error("clock phase did not toggle");

  chk_mc_twelve: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    o_mc_pulse |=> !o_mc_pulse [*8] ##1 !o_mc_pulse [*3] ##1 o_mc_pulse)
    else $error("machine cycle is not twelve clocks");

  chk_hold_qualify: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $rose(o_sys_rst) |-> $past(o_pin_high, 23))
    else $error("internal reset before two machine cycles");

endmodule : msr_rst_seq
`default_nettype wire

// ---- hw/msr_top.sv ----
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module msr_top (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_rst_pin,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic [7:0]  i_p1_pin,
  output logic      [7:0]  o_p1_out,
  output logic      [7:0]  o_p1_oe,
  output logic      [7:0]  o_p1_pullup,
  input  wire logic [7:0]  i_p3_pin,
  output logic      [7:0]  o_p3_out,
  output logic      [7:0]  o_p3_oe,
  output logic      [7:0]  o_p3_pullup,
  input  wire logic        i_cmp_out,
  output logic             o_comparator_plus_input,
  output logic             o_comparator_minus_input,
  input  wire logic        i_txd,
  output logic             o_rxd,
  output logic             o_ext_irq_zero_pin,
  output logic             o_ext_irq_one_pin,
  output logic             o_timer_zero_count_input,
  output logic             o_timer_one_count_input,
  input  wire logic [4:0]  i_irq_req,
  output logic      [10:0] o_vector_addr,
  output logic             o_vector_valid,
  output logic      [6:0]  o_stack_addr,
  input  wire logic        i_prog_mode,
  input  wire logic        i_prog_drive,
  input  wire logic [7:0]  i_prog_data,
  output logic      [7:0]  o_prog_data,
  output logic      [7:0]  o_prog_ctrl,
  output logic             o_core_run,
  output logic             o_periph_run,
  output logic             o_osc_enable,
  output logic             o_mc_pulse,
  output logic             o_clk_phase,
  output logic             o_sys_rst
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]           sfr [msr_pkg::SFR_COUNT];
  msr_pkg::msr_pwr_type pwr;
  msr_pkg::msr_pwr_type next_pwr;
  logic                 pin_high;
  logic                 sys_rst;
  logic [4:0]           acc_idx;
  logic                 ram_sel;
  logic                 sfr_hit;
  logic                 bus_ok;
  logic                 sfr_we;
  logic                 ram_we;
  logic                 power_control_we;
  logic                 wake;
  logic [4:0]           irq_live;
  logic [7:0]           p1_s1;
  logic [7:0]           p1_s2;
  logic [7:0]           p1_s3;
  logic [7:0]           p1_pin;
  logic [7:0]           p3_s1;
  logic [7:0]           p3_s2;
  logic [7:0]           p3_s3;
  logic [7:0]           p3_pin;
  logic [7:0]           p3_read;
  logic [7:0]           p3_level;
  logic [7:0]           power_control_read;
  logic [7:0]           sfr_rd_val;
  logic [7:0]           sfr_rdata;
  logic                 ram_rd;
  logic [7:0]           ram_rdata;

  // ----------------------------------------------------------------
  // Reset sequencing and clock phases
  // ----------------------------------------------------------------
  msr_rst_seq u_rst_seq (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_rst_pin   (i_rst_pin),
    .o_pin_high  (pin_high),
    .o_sys_rst   (sys_rst),
    .o_mc_pulse  (o_mc_pulse),
    .o_clk_phase (o_clk_phase)
  );

  assign o_sys_rst = sys_rst;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Everything below the special register space is internal RAM; there
  // is no path to any external memory.
  assign ram_sel  = ~i_addr[7];
  assign acc_idx  = msr_pkg::sfr_index(i_addr);
  assign sfr_hit  = acc_idx != msr_pkg::SFR_NONE;
  assign bus_ok   = (pwr == msr_pkg::PWR_RUN) & ~sys_rst;
  assign sfr_we   = i_wr & bus_ok & ~ram_sel & sfr_hit;
  assign ram_we   = i_wr & bus_ok & ram_sel;
  assign power_control_we  = sfr_we & (acc_idx == msr_pkg::IX_POWER_CONTROL);
  assign irq_live = i_irq_req & sfr[msr_pkg::IX_IE][4:0];
  assign wake     = sfr[msr_pkg::IX_IE][msr_pkg::IE_ALL_BIT]
                    & (|irq_live);

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  always_comb
  begin
    next_pwr = pwr;
    unique case (pwr)
      msr_pkg::PWR_RUN:
      begin
        if (power_control_we && i_wdata[msr_pkg::POWER_CONTROL_PD_BIT])
          next_pwr = msr_pkg::PWR_DOWN;
        else if (power_control_we && i_wdata[msr_pkg::POWER_CONTROL_IDLE_BIT])
          next_pwr = msr_pkg::PWR_IDLE;
      end
      msr_pkg::PWR_IDLE:
      begin
        if (wake)
          next_pwr = msr_pkg::PWR_RUN;
      end
      msr_pkg::PWR_DOWN:
        next_pwr = msr_pkg::PWR_DOWN;
      default:
        next_pwr = msr_pkg::PWR_RUN;
    endcase
  end

  // Only a hardware reset leaves power-down.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pwr <= msr_pkg::PWR_RUN;
    else if (sys_rst)
      pwr <= msr_pkg::PWR_RUN;
    else
      pwr <= next_pwr;
  end

  assign o_core_run   = bus_ok;
  assign o_periph_run = pwr != msr_pkg::PWR_DOWN;
  assign o_osc_enable = pwr != msr_pkg::PWR_DOWN;

  // ----------------------------------------------------------------
  // Special registers
  // ----------------------------------------------------------------
  // The pin-high force runs ahead of qualification and wins over a
  // write in the same cycle.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < msr_pkg::SFR_COUNT; i++)
        sfr[i] <= msr_pkg::SFR_RST[i];
    end
    else if (sys_rst)
    begin
      for (int i = 0; i < msr_pkg::SFR_COUNT; i++)
        sfr[i] <= msr_pkg::SFR_RST[i];
    end
    else
    begin
      if (sfr_we)
        sfr[acc_idx] <= i_wdata & msr_pkg::SFR_WMASK[acc_idx];
      if (pin_high)
      begin
        sfr[msr_pkg::IX_P1] <= msr_pkg::LATCH_ONES;
        sfr[msr_pkg::IX_P3] <= msr_pkg::LATCH_ONES;
      end
    end
  end

  assign o_stack_addr = sfr[msr_pkg::IX_SP][6:0];

  // ----------------------------------------------------------------
  // Internal RAM
  // ----------------------------------------------------------------
  msr_ram #(
    .DEPTH (msr_pkg::RAM_DEPTH),
    .WIDTH (8)
  ) u_ram (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_we      (ram_we),
    .i_addr    (i_addr[6:0]),
    .i_wdata   (i_wdata),
    .o_rdata   (ram_rdata)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      p1_s1  <= msr_pkg::LATCH_ONES;
      p1_s2  <= msr_pkg::LATCH_ONES;
      p1_s3  <= msr_pkg::LATCH_ONES;
      p1_pin <= msr_pkg::LATCH_ONES;
      p3_s1  <= msr_pkg::LATCH_ONES;
      p3_s2  <= msr_pkg::LATCH_ONES;
      p3_s3  <= msr_pkg::LATCH_ONES;
      p3_pin <= msr_pkg::LATCH_ONES;
    end
    else
    begin
      p1_s1  <= i_p1_pin;
      p1_s2  <= p1_s1;
      p1_s3  <= p1_s2;
      p1_pin <= msr_pkg::settle(p1_s2, p1_s3, p1_pin);
      p3_s1  <= i_p3_pin;
      p3_s2  <= p3_s1;
      p3_s3  <= p3_s2;
      p3_pin <= msr_pkg::settle(p3_s2, p3_s3, p3_pin);
    end
  end

  // ----------------------------------------------------------------
  // Port drivers
  // ----------------------------------------------------------------
  // Pins are open drain: a zero latch pulls low, a one releases the
  // line so that it can be read as an input.
  assign o_p1_out    = '0;
  assign o_p3_out    = '0;
  assign o_p1_oe     = i_prog_mode
                       ? (i_prog_drive ? ~i_prog_data : '0)
                       : ~sfr[msr_pkg::IX_P1];
  assign o_p1_pullup = msr_pkg::P1_PULLUP;
  assign p3_level    = sfr[msr_pkg::IX_P3]
                       & (i_txd ? msr_pkg::LATCH_ONES
                                : ~msr_pkg::TXD_MASK);
  assign o_p3_oe     = i_prog_mode ? '0
                       : ~p3_level & msr_pkg::P3_GPIO_MASK;
  assign o_p3_pullup = msr_pkg::P3_GPIO_MASK;

  assign o_comparator_plus_input  = p1_pin[msr_pkg::CMP_PLUS_BIT];
  assign o_comparator_minus_input = p1_pin[msr_pkg::CMP_MINUS_BIT];
  assign o_rxd                    = p3_pin[msr_pkg::RXD_BIT];
  assign o_ext_irq_zero_pin       = p3_pin[msr_pkg::INT0_BIT];
  assign o_ext_irq_one_pin        = p3_pin[msr_pkg::EXT_IRQ_ONE_PIN_BIT];
  assign o_timer_zero_count_input = p3_pin[msr_pkg::T0_BIT];
  assign o_timer_one_count_input  = p3_pin[msr_pkg::T1_BIT];
  assign o_prog_data              = p1_pin;
  assign o_prog_ctrl              = p3_pin & msr_pkg::P3_GPIO_MASK;

  // ----------------------------------------------------------------
  // Interrupt vector
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_vector_addr  <= msr_pkg::VEC_BASE;
      o_vector_valid <= 1'b0;
    end
    else
    begin
      o_vector_addr  <= msr_pkg::vec_addr(irq_live);
      o_vector_valid <= wake;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Port reads return the pin, and port 3 bit 6 is the comparator.
  assign p3_read   = (p3_pin & msr_pkg::P3_GPIO_MASK)
                     | (i_cmp_out ? ~msr_pkg::P3_GPIO_MASK : '0);
  assign power_control_read = sfr[msr_pkg::IX_POWER_CONTROL]
                     | ((pwr == msr_pkg::PWR_IDLE)
                        ? 8'(1 << msr_pkg::POWER_CONTROL_IDLE_BIT) : '0)
                     | ((pwr == msr_pkg::PWR_DOWN)
                        ? 8'(1 << msr_pkg::POWER_CONTROL_PD_BIT) : '0);
  // Unoccupied addresses read zero so the answer is at least defined.
  assign sfr_rd_val = !sfr_hit ? '0
                    : (acc_idx == msr_pkg::IX_P1) ? p1_pin
                    : (acc_idx == msr_pkg::IX_P3) ? p3_read
                    : (acc_idx == msr_pkg::IX_POWER_CONTROL) ? power_control_read
                    : sfr[acc_idx];

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sfr_rdata <= '0;
      ram_rd    <= 1'b0;
    end
    else
    begin
      sfr_rdata <= i_rd ? sfr_rd_val : '0;
      ram_rd    <= i_rd & ram_sel;
    end
  end

  assign o_rdata = ram_rd ? ram_rdata : sfr_rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_p1_release: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (i_wr && i_addr == 8'h90 && bus_ok && !pin_high && !i_prog_mode)
    |=> (o_p1_oe == ~$past(i_wdata)) || i_prog_mode || pin_high)
    else $error("port 1 drive does not follow latch");

  chk_p3_six_input: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    i_rd && i_addr == 8'hb0 |=> !o_p3_oe[6]
      && o_rdata[6] == $past(i_cmp_out))
    else $error("port 3 bit 6 not comparator input");

  chk_latch_force: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    pin_high |=> sfr[msr_pkg::IX_P1] == 8'hff
      && sfr[msr_pkg::IX_P3] == 8'hff)
    else $error("latches not forced high by reset pin");

  chk_reset_load: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    sys_rst |=> sfr[msr_pkg::IX_SP] == 8'h07
      && sfr[msr_pkg::IX_ACC] == 8'h00 && sfr[msr_pkg::IX_PSW] == 8'h00)
    else $error("reset values not loaded");

  chk_ram_guard: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n) sys_rst |-> !ram_we)
    else $error("RAM written during reset");

  chk_idle_wake: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    pwr == msr_pkg::PWR_IDLE && wake |=> ##1 o_core_run || sys_rst)
    else $error("idle not ended by enabled interrupt");

  chk_down_hold: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    pwr == msr_pkg::PWR_DOWN && !sys_rst |=> !o_osc_enable [*2]
      or ##[0:1] sys_rst)
    else $error("power-down left without reset");

  chk_idle_periph: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $rose(pwr == msr_pkg::PWR_IDLE) |-> o_periph_run && !o_core_run
      && $past(power_control_we))
    else $error("idle entry wrong");

  chk_unmapped_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    i_rd && i_addr[7] && !sfr_hit |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

endmodule : msr_top
`default_nettype wire

// ---- verif/msr_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------
// Board side of one eight-bit port
// --------------------------------------------------
module msr_pin_model (
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_pin
);
  // A released line floats high: the chip pull-ups, or the board
  // resistors that the two comparator bits need since they lack one.
  // A low drive from the chip wins over any board drive.
  assign o_pin = ~i_oe & ((i_ext_en & i_ext) | ~i_ext_en);
endmodule : msr_pin_model
`default_nettype wire

// ---- verif/mcu_sfr_ports_reset_core_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------
// Register, port and reset checks
// --------------------------------------------------
module mcu_sfr_ports_reset_core_tb_top;
  logic        i_clk_sys, i_rst_n, i_rst_pin, i_wr, i_rd, i_cmp_out;
  logic        i_txd, i_prog_mode, i_prog_drive;
  logic [7:0]  i_addr, i_wdata, i_p1_pin, i_p3_pin, i_prog_data;
  logic [4:0]  i_irq_req;
  logic [7:0]  o_rdata, o_p1_out, o_p1_oe, o_p1_pullup, o_p3_out;
  logic [7:0]  o_p3_oe, o_p3_pullup, o_prog_data, o_prog_ctrl;
  logic        o_comparator_plus_input, o_comparator_minus_input;
  logic        o_rxd, o_ext_irq_zero_pin, o_ext_irq_one_pin;
  logic        o_timer_zero_count_input, o_timer_one_count_input;
  logic [10:0] o_vector_addr;
  logic [6:0]  o_stack_addr;
  logic        o_vector_valid, o_core_run, o_periph_run, o_osc_enable;
  logic        o_mc_pulse, o_clk_phase, o_sys_rst, ph;
  logic [7:0]  p1_ext, p1_en, p3_ext, p3_en;
  int          mismatches, n_tests, n;

  msr_top u_dut (.*);
  msr_pin_model u_p1 (.i_oe(o_p1_oe), .i_ext(p1_ext), .i_ext_en(p1_en),
    .o_pin(i_p1_pin));
  msr_pin_model u_p3 (.i_oe(o_p3_oe), .i_ext(p3_ext), .i_ext_en(p3_en),
    .o_pin(i_p3_pin));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_rdata, e);
  endtask : rd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // Pin inputs pass three sync stages and a settle stage first.
  task automatic s_ports();
    rd(8'h81, 8'h07);
    rd(8'he0, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h98, 8'h00);
    rd(8'hd0, 8'h00);
    rd(8'h80, 8'h00);
    wr(8'h90, 8'h0f);
    p1_en <= 8'h0f;
    p1_ext <= 8'h05;
    p3_en <= 8'hff;
    p3_ext <= 8'h75;
    repeat (6) @(posedge i_clk_sys);
    chk(o_p1_oe, 8'hf0);
    rd(8'h90, 8'h05);
    chk({6'h00, o_comparator_minus_input, o_comparator_plus_input},
      8'h01);
    chk(o_p1_pullup, 8'hfc);
    rd(8'hb0, 8'h35);
    @(posedge i_clk_sys);
    i_cmp_out <= 1'b1;
    rd(8'hb0, 8'h75);
    @(posedge i_clk_sys);
    i_cmp_out <= 1'b0;
    chk({3'h0, o_timer_one_count_input, o_timer_zero_count_input,
      o_ext_irq_one_pin, o_ext_irq_zero_pin, o_rxd}, 8'h1b);
    chk(o_p3_pullup, 8'hbf);
    wr(8'hb0, 8'h00);
    @(negedge i_clk_sys);
    chk(o_p3_oe, 8'hbf);
    @(posedge i_clk_sys);
    p1_en <= 8'h00;
    p3_en <= 8'h00;
  endtask : s_ports

  task automatic s_rst_pin();
    wr(8'h81, 8'h55);
    wr(8'h10, 8'ha5);
    wr(8'h90, 8'h00);
    @(posedge i_clk_sys);
    i_rst_pin <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(o_p1_oe, 8'h00);
    chk({7'h00, o_sys_rst}, 8'h00);
    repeat (30) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk({7'h00, o_sys_rst}, 8'h01);
    @(posedge i_clk_sys);
    i_rst_pin <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    rd(8'h81, 8'h07);
    rd(8'h10, 8'ha5);
    chk(o_p3_oe, 8'h00);
  endtask : s_rst_pin

  // Idle wakes on an enabled request; power-down waits for the pin.
  task automatic s_power();
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'h1f);
    wr(8'h81, 8'h2a);
    @(negedge i_clk_sys);
    chk({1'b0, o_stack_addr}, 8'h2a);
    @(posedge i_clk_sys);
    i_txd <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_p3_oe, 8'h02);
    @(posedge i_clk_sys);
    i_txd <= 1'b1;
    wr(8'ha8, 8'h84);
    wr(8'h87, 8'h01);
    @(negedge i_clk_sys);
    chk({5'h00, o_core_run, o_periph_run, o_osc_enable}, 8'h03);
    rd(8'h87, 8'h01);
    wr(8'h81, 8'h11);
    rd(8'h81, 8'h2a);
    @(posedge i_clk_sys);
    i_irq_req <= 5'h04;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk({5'h00, o_core_run, o_periph_run, o_osc_enable}, 8'h07);
    chk({7'h00, o_vector_valid}, 8'h01);
    chk(o_vector_addr[7:0], 8'h13);
    chk({5'h00, o_vector_addr[10:8]}, 8'h00);
    @(posedge i_clk_sys);
    i_irq_req <= 5'h00;
    wr(8'h87, 8'h02);
    @(posedge i_clk_sys);
    i_irq_req <= 5'h04;
    wr(8'h81, 8'h33);
    rd(8'h81, 8'h2a);
    chk({5'h00, o_core_run, o_periph_run, o_osc_enable}, 8'h00);
    @(posedge i_clk_sys);
    i_rst_pin <= 1'b1;
    repeat (30) @(posedge i_clk_sys);
    i_rst_pin <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_irq_req <= 5'h00;
    @(negedge i_clk_sys);
    chk({5'h00, o_core_run, o_periph_run, o_osc_enable}, 8'h07);
  endtask : s_power

  task automatic s_prog();
    @(posedge i_clk_sys);
    i_prog_mode <= 1'b1;
    i_prog_drive <= 1'b1;
    i_prog_data <= 8'h5a;
    p3_en <= 8'hff;
    p3_ext <= 8'h0c;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(o_p1_oe, 8'ha5);
    chk(o_p3_oe, 8'h00);
    chk(o_prog_data, 8'h5a);
    chk(o_prog_ctrl, 8'h0c);
    @(posedge i_clk_sys);
    i_prog_drive <= 1'b0;
    p1_en <= 8'hff;
    p1_ext <= 8'h3c;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(o_prog_data, 8'h3c);
    @(posedge i_clk_sys);
    {i_prog_mode, p1_en, p3_en} <= '0;
  endtask : s_prog

  task automatic s_clock();
    for (n = 0; n < 20 && o_mc_pulse !== 1'b1; n++)
      @(negedge i_clk_sys);
    ph = o_clk_phase;
    n = 0;
    do
    begin
      @(negedge i_clk_sys);
      n++;
    end
    while (o_mc_pulse !== 1'b1 && n < 20);
    chk(8'(n), 8'h0c);
    chk({7'h00, o_clk_phase}, {7'h00, ph ^ n[0]});
    @(negedge i_clk_sys);
    chk({7'h00, o_clk_phase}, {7'h00, ~ph});
  endtask : s_clock

  initial
  begin
    {i_rst_n, i_rst_pin, i_wr, i_rd, i_cmp_out, i_prog_mode} = '0;
    {i_prog_drive, i_addr, i_wdata, i_prog_data, i_irq_req} = '0;
    {p1_ext, p1_en, p3_ext, p3_en, mismatches, n_tests} = '0;
    i_txd = 1'b1;
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    s_ports();
    s_rst_pin();
    s_power();
    s_prog();
    s_clock();
    complete_run();
  end

  // The run needs some 200 cycles; this allows about ten times that.
  initial
  begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule : mcu_sfr_ports_reset_core_tb_top
`default_nettype wire
